// File: lpcg_pkg.sv
// Package: register map, field layout and state encodings of the low-power clock gating control
package lpcg_pkg;

   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [11:0] LPCG_RUN_GATING_REG2_OFF = 12'h108;
   localparam logic [11:0] LPCG_SLEEP_GATING_REG2_OFF = 12'h118;
   localparam logic [11:0] LPCG_DEEP_SLEEP_GATING_REG2_OFF = 12'h128;
   localparam logic [11:0] LPCG_RUN_CLOCK_CONFIG_OFF = 12'h060;
   localparam logic [11:0] LPCG_MODE_CTRL_OFF = 12'h200;
   localparam logic [11:0] LPCG_FAULT_STATUS_OFF = 12'h204;
   localparam logic [31:0] LPCG_SYSCTL_BASE = 32'h400FE000;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int LPCG_ETH_PHY_BIT = 30;
   localparam int LPCG_ETH_MAC_BIT = 28;
   localparam int LPCG_PORT_A_BIT = 0;
   localparam int LPCG_NUM_PORTS = 7;
   localparam int LPCG_NUM_UNITS = 9;
   localparam int LPCG_AUTO_GATING_BIT = 27;

   // Writable masks
   localparam logic [31:0] LPCG_GATE2_MASK = 32'h5000007F;
   localparam logic [31:0] LPCG_SLEEP2_MASK = 32'h0000003F;
   localparam logic [31:0] LPCG_RCC_MASK = 32'h08000000;
   localparam logic [31:0] LPCG_MODE_MASK = 32'h00000003;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [31:0] LPCG_GATE2_RESET = 32'h00000000;
   localparam logic [31:0] LPCG_RCC_RESET = 32'h00000000;

   // Power state, one-hot
   typedef enum logic [2:0]
   {
      LPCG_ST_RUN = 3'h1,
      LPCG_ST_SLEEP = 3'h2,
      LPCG_ST_DEEP = 3'h4
   } lpcg_state_t;

   localparam logic [1:0] LPCG_MODE_RUN = 2'h0;
   localparam logic [1:0] LPCG_MODE_SLEEP = 2'h1;
   localparam logic [1:0] LPCG_MODE_DEEP = 2'h2;

endpackage : lpcg_pkg

// File: lpcg_unit_guard.sv
// Per-unit clock gate and bus-fault guard for one peripheral
`timescale 1ns/1ps

module lpcg_unit_guard
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic enable,
   input wire logic unit_access,
   output logic unit_clk_en,
   output logic unit_disable,
   output logic unit_fault
);

   // Registered so the gate enable never glitches mid-cycle
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         unit_clk_en <= 1'b0;
         unit_disable <= 1'b1;
         unit_fault <= 1'b0;
      end
      else
      begin
         unit_clk_en <= enable;
         unit_disable <= ~enable;
         unit_fault <= unit_access & ~enable;
      end
   end

endmodule : lpcg_unit_guard

// File: lpcg_ctrl.sv
// Top: low-power clock gating control with APB register slave
//
// Contract
// - A peripheral gets its clock when its gating bit is one, otherwise it is stopped and held disabled.
// - Any access to a peripheral whose clock is gated off is answered with a bus fault.
// - Every gating bit is zero after reset so all controlled peripherals start unclocked.
// - Separate run, sleep and deep-sleep gating registers exist; run and deep-sleep share one bit assignment, sleep holds ports F to A only.
// - Sleep and deep-sleep gating registers act only while the auto-gating bit is set.
// - The deep-sleep gating register is a 32-bit word at offset 0x128 of the system control base.
// - Bit 30 of the deep-sleep register enables the Ethernet PHY clock in deep sleep.
// - Bit 28 of the deep-sleep register enables the Ethernet MAC clock in deep sleep.
// - Bits 6 to 0 of the deep-sleep register enable ports G to A in deep sleep.
// - Bits 31, 29 and 27:7 are read-only zero; software keeps them unchanged.
// - Bits 5 to 0 of the sleep register enable ports F to A and reset to zero.
`timescale 1ns/1ps

module lpcg_ctrl
(
   input wire logic clk_sys,
   input wire logic reset,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Accesses toward gated units: [6:0] ports A..G, [7] MAC, [8] PHY
   input wire logic [8:0] unit_access,
   output logic [8:0] unit_clk_en,
   output logic [8:0] unit_disable,
   output logic [8:0] unit_fault,
   output logic [2:0] power_state
);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [31:0] run_gating_reg2;
   logic [31:0] sleep_gating_reg2;
   logic [31:0] deep_sleep_gating_reg2;
   logic [31:0] run_clock_config;
   logic [1:0] mode_request;
   logic [8:0] fault_seen;
   lpcg_pkg::lpcg_state_t state;
   lpcg_pkg::lpcg_state_t next_state;

   // Maps a gating register to the unit vector: ports, MAC, PHY
   function automatic logic [8:0] lpcg_units(input logic [31:0] r);
      lpcg_units = {r[lpcg_pkg::LPCG_ETH_PHY_BIT], r[lpcg_pkg::LPCG_ETH_MAC_BIT],
                    r[lpcg_pkg::LPCG_PORT_A_BIT +: lpcg_pkg::LPCG_NUM_PORTS]};
   endfunction : lpcg_units

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   wire setup = psel & ~penable;
   wire access = psel & penable;
   wire wr = access & pwrite;
   wire hit_run = (paddr == lpcg_pkg::LPCG_RUN_GATING_REG2_OFF);
   wire hit_sleep = (paddr == lpcg_pkg::LPCG_SLEEP_GATING_REG2_OFF);
   wire hit_deep = (paddr == lpcg_pkg::LPCG_DEEP_SLEEP_GATING_REG2_OFF);
   wire hit_rcc = (paddr == lpcg_pkg::LPCG_RUN_CLOCK_CONFIG_OFF);
   wire hit_mode = (paddr == lpcg_pkg::LPCG_MODE_CTRL_OFF);
   wire hit_fault = (paddr == lpcg_pkg::LPCG_FAULT_STATUS_OFF);
   wire hit_any = hit_run | hit_sleep | hit_deep | hit_rcc | hit_mode | hit_fault;
   wire auto_gating_select = run_clock_config[lpcg_pkg::LPCG_AUTO_GATING_BIT];

   logic [31:0] read_mux;
   assign read_mux = hit_run ? run_gating_reg2 :
                     hit_sleep ? sleep_gating_reg2 :
                     hit_deep ? deep_sleep_gating_reg2 :
                     hit_rcc ? run_clock_config :
                     hit_mode ? {30'h0, mode_request} :
                     hit_fault ? {23'h0, fault_seen} : 32'h00000000;

   // No wait state: answer in the cycle after the setup phase
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
      else
      begin
         pready <= setup;
         pslverr <= setup & ~hit_any;
         prdata <= (setup & ~pwrite & hit_any) ? read_mux : 32'h00000000;
      end
   end

   wire wr_done = wr & pready;

   // Reserved bits never store: masks keep them zero
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         run_gating_reg2 <= lpcg_pkg::LPCG_GATE2_RESET;
         sleep_gating_reg2 <= lpcg_pkg::LPCG_GATE2_RESET;
         deep_sleep_gating_reg2 <= lpcg_pkg::LPCG_GATE2_RESET;
         run_clock_config <= lpcg_pkg::LPCG_RCC_RESET;
         mode_request <= lpcg_pkg::LPCG_MODE_RUN;
      end
      else if (wr_done)
      begin
         if (hit_run)
            run_gating_reg2 <= pwdata & lpcg_pkg::LPCG_GATE2_MASK;
         else if (hit_sleep)
            sleep_gating_reg2 <= pwdata & lpcg_pkg::LPCG_SLEEP2_MASK;
         else if (hit_deep)
            deep_sleep_gating_reg2 <= pwdata & lpcg_pkg::LPCG_GATE2_MASK;
         else if (hit_rcc)
            run_clock_config <= pwdata & lpcg_pkg::LPCG_RCC_MASK;
         else if (hit_mode)
            mode_request <= pwdata[1:0] & lpcg_pkg::LPCG_MODE_MASK[1:0];
      end
   end

   // ----------------------------------------
   // Power state machine
   // ----------------------------------------
   always_comb
   begin
      next_state = state;
      case (mode_request)
         lpcg_pkg::LPCG_MODE_SLEEP: next_state = lpcg_pkg::LPCG_ST_SLEEP;
         lpcg_pkg::LPCG_MODE_DEEP: next_state = lpcg_pkg::LPCG_ST_DEEP;
         default: next_state = lpcg_pkg::LPCG_ST_RUN;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         state <= lpcg_pkg::LPCG_ST_RUN;
         power_state <= 3'h1;
      end
      else
      begin
         state <= next_state;
         power_state <= next_state;
      end
   end

   // Low-power registers only take over when auto gating is on
   logic [31:0] active_gate;
   always_comb
   begin
      active_gate = run_gating_reg2;
      case (state)
         lpcg_pkg::LPCG_ST_SLEEP:
            if (auto_gating_select)
               active_gate = sleep_gating_reg2;
         lpcg_pkg::LPCG_ST_DEEP:
            if (auto_gating_select)
               active_gate = deep_sleep_gating_reg2;
         default: active_gate = run_gating_reg2;
      endcase
   end

   wire [8:0] unit_enable = lpcg_units(active_gate);
   wire [8:0] fault_raw;

   // ----------------------------------------
   // Per-unit gates
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < lpcg_pkg::LPCG_NUM_UNITS; gi++)
      begin : g_unit
         lpcg_unit_guard u_guard
         (
            .clk_sys(clk_sys),
            .reset(reset),
            .enable(unit_enable[gi]),
            .unit_access(unit_access[gi]),
            .unit_clk_en(unit_clk_en[gi]),
            .unit_disable(unit_disable[gi]),
            .unit_fault(fault_raw[gi])
         );
      end
   endgenerate

   assign unit_fault = fault_raw;

   // Sticky record of faults; write-one-to-clear, a new fault wins over the clear
   wire [8:0] fault_clr = (wr_done & hit_fault) ? pwdata[8:0] : 9'h000;
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         fault_seen <= 9'h000;
      else
         fault_seen <= (fault_seen & ~fault_clr) | fault_raw;
   end

endmodule : lpcg_ctrl

// File: lpcg_ctrl_assertions.sv
// Port-level assertions for the clock gating control
`timescale 1ns/1ps
module lpcg_ctrl_checker
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [8:0] unit_access,
   input wire logic [8:0] unit_clk_en,
   input wire logic [8:0] unit_disable,
   input wire logic [8:0] unit_fault,
   input wire logic [2:0] power_state
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
   a_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
   a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
   a_deep_no_err: assert property (psel && !penable && paddr == 12'h128 |=> !pslverr)
      else $error("deep register refused");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h00000000) else $error("read data outside answer");
   a_disable_inverse: assert property (unit_disable == ~unit_clk_en) else $error("disable not inverse");
   // Only judged while gating is steady; fault and disable are registered from the same enable on the same edge
   a_fault_gated: assert property ($stable(unit_disable) |-> unit_fault == ($past(unit_access) & unit_disable))
      else $error("fault wrong");
   a_reset_gated: assert property ($fell(reset) |-> unit_clk_en == 9'h000) else $error("clock on after reset");
   a_state_onehot: assert property ($onehot(power_state)) else $error("state not one-hot");
endmodule : lpcg_ctrl_checker
bind lpcg_ctrl lpcg_ctrl_checker lpcg_ctrl_checker_i (.clk_sys(clk_sys), .reset(reset), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .unit_access(unit_access), .unit_clk_en(unit_clk_en), .unit_disable(unit_disable),
   .unit_fault(unit_fault), .power_state(power_state));

// File: tb_top.sv
// Self-checking bench for the clock gating control
`timescale 1ns/1ps
module tb_top;
   localparam logic [11:0] SLP = lpcg_pkg::LPCG_SLEEP_GATING_REG2_OFF;
   localparam logic [11:0] MODE = lpcg_pkg::LPCG_MODE_CTRL_OFF;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [8:0] unit_access = 9'h000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [8:0] unit_clk_en;
   logic [8:0] unit_disable;
   logic [8:0] unit_fault;
   logic [2:0] power_state;
   logic [31:0] rd;
   logic er;
   int n_errors = 0;
   int check_count = 0;
   always #4 clk_sys = ~clk_sys;
   lpcg_ctrl lpcg_ctrl_i (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .unit_access(unit_access), .unit_clk_en(unit_clk_en), .unit_disable(unit_disable),
      .unit_fault(unit_fault), .power_state(power_state));
   task complete_run();
      if (n_errors == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run
   task check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   // Waits for pready without assuming the answer latency
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
         n_errors++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      check(rd, exp);
   endtask : rd_chk
   // Gate follows a write or mode change within two edges
   task gate_chk(input logic [8:0] exp);
      repeat (3) @(posedge clk_sys);
      check({23'h000000, unit_clk_en}, {23'h000000, exp});
   endtask : gate_chk
   initial
   begin
      repeat (10) @(posedge clk_sys);
      reset <= 1'b0;
      check({29'h00000000, power_state}, 32'h00000001);
      rd_chk(12'h128, 32'h00000000);
      check({31'h00000000, er}, 32'h00000000);
      rd_chk(SLP, 32'h00000000);
      gate_chk(9'h000);
      apb(1'b1, 12'h128, 32'hFFFFFFFF);
      rd_chk(12'h128, 32'h5000007F);
      apb(1'b1, SLP, 32'hFFFFFFFF);
      rd_chk(SLP, 32'h0000003F);
      apb(1'b1, 12'h128, 32'h10000041);
      apb(1'b1, SLP, 32'h00000015);
      apb(1'b1, lpcg_pkg::LPCG_RUN_GATING_REG2_OFF, 32'h40000002);
      rd_chk(lpcg_pkg::LPCG_RUN_GATING_REG2_OFF, 32'h40000002);
      gate_chk(9'h102);
      apb(1'b1, MODE, 32'h00000002);
      gate_chk(9'h102);
      check({29'h00000000, power_state}, 32'h00000004);
      apb(1'b1, lpcg_pkg::LPCG_RUN_CLOCK_CONFIG_OFF, 32'h08000000);
      rd_chk(lpcg_pkg::LPCG_RUN_CLOCK_CONFIG_OFF, 32'h08000000);
      gate_chk(9'h0C1);
      apb(1'b1, MODE, 32'h00000001);
      gate_chk(9'h015);
      check({29'h00000000, power_state}, 32'h00000002);
      apb(1'b1, 12'h128, 32'h40000000);
      apb(1'b1, MODE, 32'h00000002);
      gate_chk(9'h100);
      unit_access <= 9'h1FF;
      repeat (2) @(posedge clk_sys);
      check({23'h000000, unit_fault}, 32'h000000FF);
      check({23'h000000, unit_disable}, 32'h000000FF);
      unit_access <= 9'h000;
      rd_chk(lpcg_pkg::LPCG_FAULT_STATUS_OFF, 32'h000000FF);
      apb(1'b1, lpcg_pkg::LPCG_FAULT_STATUS_OFF, 32'h000001FF);
      rd_chk(lpcg_pkg::LPCG_FAULT_STATUS_OFF, 32'h00000000);
      // Code 3 is not a low-power request, so the run register applies
      apb(1'b1, MODE, 32'h00000003);
      gate_chk(9'h102);
      check({29'h00000000, power_state}, 32'h00000001);
      // Reset in mid-run must clear gating that software had turned on
      reset <= 1'b1;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      rd_chk(12'h128, 32'h00000000);
      rd_chk(lpcg_pkg::LPCG_RUN_GATING_REG2_OFF, 32'h00000000);
      gate_chk(9'h000);
      check({23'h000000, unit_disable}, 32'h000001FF);
      check({29'h00000000, power_state}, 32'h00000001);
      apb(1'b0, 12'h300, 32'h00000000);
      check({31'h00000000, er}, 32'h00000001);
      check(rd, 32'h00000000);
      complete_run();
   end
   initial
   begin
      #100000;
      n_errors++;
      complete_run();
   end
endmodule : tb_top
